// *** design/dpw_serial_wiper_ctrl.sv ***
`timescale 1ns/1ps

package dpw_pkg;
   localparam int         NUM_POTS     = 2;
   localparam int         NUM_PRESETS  = 4;
   localparam int         NUM_TAPS     = 256;
   localparam logic [2:0] BIT_LAST     = 3'h7;
   localparam logic [3:0] READ_BITS    = 4'h8;
   localparam logic [3:0] OP_RD_WIPER  = 4'h9;
   localparam logic [3:0] OP_WR_WIPER  = 4'hA;
   localparam logic [3:0] OP_RD_PRESET = 4'hB;
   localparam logic [3:0] OP_WR_PRESET = 4'hC;
   localparam logic [7:0] PRESET_RST   = 8'h80;
   localparam logic [7:0] WIPER_RST    = 8'h00;

   typedef struct packed {
      logic csN;
      logic holdN;
      logic sck;
      logic si;
   } dpw_pins_t;

   typedef struct packed {
      logic [3:0] op;
      logic [1:0] regSel;
      logic       potSel;
   } dpw_instr_t;

   typedef enum {ST_ID, ST_INSTR, ST_DATA, ST_READ, ST_IGNORE} dpw_state_t;
endpackage

// Overview of operation
// [RULE1] read bits change on serial clock falling
// [RULE2] input bits sampled on serial clock rising
// [RULE3] pause input freezes sequence, resumes later intact
// [RULE4] master lowers pause only while clock low
// [RULE5] master raises pause only while clock low
// [RULE6] master keeps pause high when unused
// [RULE7] selected only when chip-select low, pause high
// [RULE8] received 4-bit address must match address pins
// [RULE9] each pot offers 256 tap positions
// [RULE10] wiper plus four presets per pot, read/write
// [RULE11] wiper register value picks the tap switch
// [RULE12] power-up copies preset zero into wiper
// [RULE13] first byte: type code high, address low
// [RULE14] chip-select high: deselected, output high impedance
// [RULE15] master gives chip-select fall before operating
// [RULE16] wiper value decodes to exactly one switch
// [RULE17] address mismatch ignores rest, output stays off
module dpw_serial_wiper_ctrl #(
   parameter logic [3:0] DEVICE_TYPE = 4'hA  // arbitrary value
) (
   // clock and reset
   input  wire logic                                    core_clk,
   input  wire logic                                    rstn,
   // serial bus pins
   input  wire dpw_pkg::dpw_pins_t                      pinsIn,
   input  wire logic [3:0]                              slaveAddrPins,
   output logic                                         soOut,
   output logic                                         soOe,
   // potentiometer taps
   output logic [dpw_pkg::NUM_POTS-1:0][7:0]            wiperPos,
   output logic [dpw_pkg::NUM_POTS-1:0][dpw_pkg::NUM_TAPS-1:0] tapSel
);
   import dpw_pkg::*;

   function automatic logic [NUM_TAPS-1:0] tapOneHot(input logic [7:0] pos);
      tapOneHot = {{(NUM_TAPS-1){1'b0}}, 1'b1} << pos;
   endfunction

   dpw_pins_t  pinsMeta_ff;
   dpw_pins_t  pinsSync_ff;
   logic       sckDly_ff;
   logic [3:0] addrMeta_ff;
   logic [3:0] addrSync_ff;
   dpw_state_t state_ff;
   logic [2:0] bitCnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] outSh_ff;
   logic [3:0] readCnt_ff;
   logic       drive_ff;
   logic       soOut_ff;
   logic       recall_ff;
   dpw_instr_t instr_ff;
   logic [7:0] wiper_ff  [NUM_POTS];
   logic [7:0] preset_ff [NUM_POTS][NUM_PRESETS];

   // pin synchronisers
   always_ff @(posedge core_clk) begin
      pinsMeta_ff <= pinsIn;
      pinsSync_ff <= pinsMeta_ff;
      sckDly_ff   <= pinsSync_ff.sck;
      addrMeta_ff <= slaveAddrPins;
      addrSync_ff <= addrMeta_ff;
   end

   wire        csHigh   = pinsSync_ff.csN;
   wire        selected = ~pinsSync_ff.csN & pinsSync_ff.holdN;           // RULE7
   wire        sckRise  = selected & pinsSync_ff.sck & ~sckDly_ff;        // RULE2
   wire        sckFall  = selected & ~pinsSync_ff.sck & sckDly_ff;        // RULE1
   wire [7:0]  shIn     = {shift_ff[6:0], pinsSync_ff.si};
   wire        byteDone = sckRise & (bitCnt_ff == BIT_LAST);
   wire        idMatch  = (shIn[7:4] == DEVICE_TYPE) && (shIn[3:0] == addrSync_ff); // RULE8
   dpw_instr_t instrIn;
   assign instrIn = '{op: shIn[7:4], regSel: shIn[3:2], potSel: shIn[0]};
   wire        isRead   = (instrIn.op == OP_RD_WIPER) || (instrIn.op == OP_RD_PRESET);
   wire        isWrite  = (instrIn.op == OP_WR_WIPER) || (instrIn.op == OP_WR_PRESET);
   wire [7:0]  rdData   = (instrIn.op == OP_RD_WIPER) ? wiper_ff[instrIn.potSel]
                        : preset_ff[instrIn.potSel][instrIn.regSel];             // RULE10
   wire        wrWiper  = (state_ff == ST_DATA) & byteDone & (instr_ff.op == OP_WR_WIPER);
   wire        wrPreset = (state_ff == ST_DATA) & byteDone & (instr_ff.op == OP_WR_PRESET);

   dpw_state_t nxt_state;
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_ID:     if (byteDone) begin
            nxt_state = idMatch ? ST_INSTR : ST_IGNORE;                     // RULE17
         end
         ST_INSTR:  if (byteDone) begin
            nxt_state = isRead ? ST_READ : (isWrite ? ST_DATA : ST_IGNORE);
         end
         ST_DATA:   if (byteDone) begin
            nxt_state = ST_IGNORE;
         end
         ST_READ:   if (sckFall && readCnt_ff == READ_BITS) begin
            nxt_state = ST_IGNORE;
         end
         ST_IGNORE: nxt_state = ST_IGNORE;
         default:   nxt_state = ST_IGNORE;
      endcase
      if (csHigh) begin
         nxt_state = ST_ID;                                                 // RULE13
      end
   end

   // sequence state; with pause low no edge is seen so all of it holds
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_ff  <= ST_ID;
         bitCnt_ff <= 3'h0;
         shift_ff  <= 8'h00;
         instr_ff  <= '0;
      end else begin
         state_ff <= nxt_state;                                             // RULE3
         if (csHigh) begin
            bitCnt_ff <= 3'h0;
         end else if (sckRise) begin
            bitCnt_ff <= bitCnt_ff + 3'h1;
            shift_ff  <= shIn;                                              // RULE2
         end
         if (state_ff == ST_INSTR && byteDone) begin
            instr_ff <= instrIn;
         end
      end
   end

   // read data path, loaded on last instruction rising edge, shifts on falling edges
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         outSh_ff   <= 8'h00;
         readCnt_ff <= 4'h0;
         drive_ff   <= 1'b0;
         soOut_ff   <= 1'b0;
      end else if (csHigh) begin
         readCnt_ff <= 4'h0;
         drive_ff   <= 1'b0;
      end else if (state_ff == ST_INSTR && byteDone && isRead) begin
         outSh_ff   <= rdData;
         readCnt_ff <= 4'h0;
      end else if (state_ff == ST_READ && sckFall) begin
         if (readCnt_ff == READ_BITS) begin
            drive_ff <= 1'b0;
         end else begin
            soOut_ff   <= outSh_ff[7];                                      // RULE1
            outSh_ff   <= {outSh_ff[6:0], 1'b0};
            readCnt_ff <= readCnt_ff + 4'h1;
            drive_ff   <= 1'b1;
         end
      end
   end

   assign soOut = soOut_ff;
   assign soOe  = drive_ff & selected & (state_ff == ST_READ);              // RULE14

   // wiper and preset registers
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         recall_ff <= 1'b1;
         for (int p = 0; p < NUM_POTS; p++) begin
            // differs from preset so a missing recall shows
            wiper_ff[p] <= WIPER_RST;
            for (int r = 0; r < NUM_PRESETS; r++) begin
               preset_ff[p][r] <= PRESET_RST;
            end
         end
      end else begin
         recall_ff <= 1'b0;
         for (int p = 0; p < NUM_POTS; p++) begin
            if (recall_ff) begin
               wiper_ff[p] <= preset_ff[p][0];                              // RULE12
            end else if (wrWiper && instr_ff.potSel == p[0]) begin
               wiper_ff[p] <= shIn;                                         // RULE10
            end
            for (int r = 0; r < NUM_PRESETS; r++) begin
               if (wrPreset && instr_ff.potSel == p[0] && instr_ff.regSel == r[1:0]) begin
                  preset_ff[p][r] <= shIn;                                  // RULE10
               end
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_POTS; g++) begin : gPot
         assign wiperPos[g] = wiper_ff[g];                                  // RULE11
         assign tapSel[g]   = tapOneHot(wiper_ff[g]);                       // RULE16 RULE9
      end
   endgenerate

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   so_fall_edge_a: assert property ( // RULE1
      $changed(soOut) |-> $past(sckFall))
      else $error("serial output changed without a falling clock edge");

   shift_rise_a: assert property ( // RULE2
      $changed(shift_ff) |-> $past(sckRise) && shift_ff[0] == $past(pinsSync_ff.si))
      else $error("input shift without a rising clock edge");

   hold_freeze_a: assert property ( // RULE3
      (!pinsSync_ff.holdN && !pinsSync_ff.csN)
      |=> $stable(state_ff) && $stable(bitCnt_ff) && $stable(shift_ff))
      else $error("sequence moved while paused");

   hold_deselect_a: assert property ( // RULE7
      (!pinsSync_ff.holdN || pinsSync_ff.csN) |-> !soOe && !sckRise && !sckFall)
      else $error("device active while not selected");

   addr_match_a: assert property ( // RULE8
      (state_ff == ST_ID && byteDone && shIn[3:0] != addrSync_ff && !csHigh)
      |=> state_ff == ST_IGNORE)
      else $error("mismatched address was accepted");

   ignore_quiet_a: assert property ( // RULE17
      (state_ff == ST_IGNORE && !csHigh) |=> state_ff == ST_IGNORE && !soOe)
      else $error("ignored sequence resumed or drove output");

   cs_high_z_a: assert property ( // RULE14
      csHigh |=> !soOe && state_ff == ST_ID)
      else $error("output driven while chip-select high");

   recall_load_a: assert property ( // RULE12
      recall_ff |=> wiper_ff[0] == $past(preset_ff[0][0])
                 && wiper_ff[1] == $past(preset_ff[1][0]))
      else $error("preset zero not recalled after reset");

   wiper_write_a: assert property ( // RULE10
      wrWiper |=> wiper_ff[instr_ff.potSel] == $past(shIn))
      else $error("wiper write lost");

   tap_onehot_a: assert property ( // RULE16
      $onehot(tapSel[0]) && tapSel[0][wiperPos[0]] && $onehot(tapSel[1]) && tapSel[1][wiperPos[1]])
      else $error("tap select not one-hot at wiper value");
endmodule

// *** tb/dpw_spi_master.sv ***
`timescale 1ns/1ps
module dpw_spi_master (
   // clock
   input  wire logic          core_clk,
   // serial bus
   output dpw_pkg::dpw_pins_t pins,
   input  wire logic          soOut,
   input  wire logic          soOe,
   // read result
   output logic               rxDone,
   output logic [7:0]         rxByte
);
   import dpw_pkg::*;
   logic [7:0] r;
   initial begin
      pins = 4'b1100;
      rxDone = 1'b0;
      rxByte = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // mode 0, msb first; optional pause before bit pa
   task automatic xfer(input logic [7:0] tx, input int pa);
      for (int i = 7; i >= 0; i--) begin
         if (i == pa) begin
            tick(4);
            pins.holdN <= 1'b0;
            repeat (3) begin
               tick(4);
               pins.sck <= 1'b1;
               pins.si <= ~pins.si;
               tick(4);
               pins.sck <= 1'b0;
            end
            tick(4);
            pins.holdN <= 1'b1;
         end
         pins.si <= tx[i];
         tick(4);
         pins.sck <= 1'b1;
         tick(4);
         r[i] = soOe ? soOut : 1'b1; // released line pulled up
         pins.sck <= 1'b0;
      end
   endtask
   task automatic frame(input logic [7:0] id, ins, d, input bit rd, input int pa);
      pins.csN <= 1'b0;
      tick(4);
      xfer(id, -1);
      xfer(ins, -1);
      xfer(d, pa);
      rxByte <= r;
      rxDone <= rd;
      tick(1);
      rxDone <= 1'b0;
      tick(3);
      pins.csN <= 1'b1;
      pins.si <= ~pins.si;
      tick(8);
   endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
   import dpw_pkg::*;
   localparam logic [3:0] DEV = 4'h6; // arbitrary value
   logic       core_clk = 1'b0;
   logic       rstn = 1'b0;
   logic       soOut;
   logic       soOe;
   logic       rxDone;
   logic       quiet = 1'b0;
   logic [3:0] slaveAddrPins;
   logic [3:0] addr;
   logic [7:0] v;
   logic [7:0] id;
   logic [7:0] rxByte;
   logic [7:0] expQ[$];
   dpw_pins_t  pins;
   int         err_total = 0;
   int         tests_run = 0;
   int         cycles = 0;
   int         csHi = 0;
   int         seed = 32'h31ed_9a3f;
   logic [NUM_POTS-1:0][7:0]          wiperPos;
   logic [NUM_POTS-1:0][NUM_TAPS-1:0] tapSel;
   always #10 core_clk = ~core_clk;
   dpw_serial_wiper_ctrl #(.DEVICE_TYPE(DEV)) u_dut (.core_clk(core_clk), .rstn(rstn),
      .pinsIn(pins), .slaveAddrPins(slaveAddrPins), .soOut(soOut), .soOe(soOe),
      .wiperPos(wiperPos), .tapSel(tapSel));
   dpw_spi_master u_mst (.core_clk(core_clk), .pins(pins), .soOut(soOut), .soOe(soOe),
      .rxDone(rxDone), .rxByte(rxByte));
   task automatic check(input string what, input logic [255:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      csHi = pins.csN ? csHi + 1 : 0;
      if (rxDone) check("read byte", rxByte, expQ.pop_front());
      if (csHi > 4 || quiet) check("so enable", soOe, 1'b0);
      if (cycles == 20000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      addr = 4'($random(seed));
      slaveAddrPins <= addr;
      id = {DEV, addr};
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge core_clk);
      for (int p = 0; p < NUM_POTS; p++) begin
         check("reset wiper", wiperPos[p], PRESET_RST);
         check("reset taps", tapSel[p], 256'h1 << PRESET_RST);
      end
      expQ.push_back(PRESET_RST);
      u_mst.frame(id, {OP_RD_PRESET, 4'h1}, 8'hFF, 1'b1, -1);
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         u_mst.frame(id, {OP_WR_PRESET, 2'(i / 2), 1'b0, 1'(i)}, v, 1'b0, -1);
         expQ.push_back(v);
         u_mst.frame(id, {OP_RD_PRESET, 2'(i / 2), 1'b0, 1'(i)}, 8'hFF, 1'b1, -1);
      end
      for (int i = 0; i < 6; i++) begin
         v = i < 2 ? 8'h00 : i < 4 ? 8'hFF : 8'($random(seed));
         u_mst.frame(id, {OP_WR_WIPER, 3'h0, 1'(i)}, v, 1'b0, i == 5 ? 3 : -1);
         check("wiper", wiperPos[i % 2], v);
         check("taps", tapSel[i % 2], 256'h1 << v);
         expQ.push_back(v);
         u_mst.frame(id, {OP_RD_WIPER, 3'h0, 1'(i)}, 8'hFF, 1'b1, -1);
      end
      quiet <= 1'b1;
      u_mst.frame({DEV, ~addr}, {OP_WR_WIPER, 4'h1}, ~v, 1'b0, -1);
      u_mst.frame({~DEV, addr}, {OP_RD_WIPER, 4'h1}, 8'hFF, 1'b0, -1);
      u_mst.frame(id, {4'h0, 4'h1}, ~v, 1'b0, -1);
      quiet <= 1'b0;
      check("ignored write", wiperPos[1], v);
      conclude();
   end
endmodule
